// ### dv/mcu_idle_powerdown_emulation_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_idle_powerdown_emulation_ctrl_test;
  typedef struct packed
  {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic e;
  } mpe_row_t;
  localparam logic [11:0] PC = mpe_pkg::POWER_CONTROL_ADDR;
  localparam logic [11:0] CF = mpe_pkg::CFG_ADDR;
  localparam logic [11:0] RB = mpe_pkg::RAM_BASE;
  localparam mpe_row_t ROWS [10] = '{
    '{1'b0, PC, 32'h0, 1'b0}, '{1'b1, PC, 32'hc, 1'b0},
    '{1'b0, PC, 32'hc, 1'b0}, '{1'b1, CF, 32'h6, 1'b0},
    '{1'b0, CF, 32'h6, 1'b0}, '{1'b1, mpe_pkg::PORT_ADDR, 32'hffa5, 1'b0},
    '{1'b1, RB, 32'h55, 1'b0}, '{1'b0, RB, 32'h55, 1'b0},
    '{1'b0, 12'h200, 32'h0, 1'b1}, '{1'b1, 12'h002, 32'h0, 1'b1}};
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, rst_pin, e;
  logic instr_done, irq_pending, irq0_n, irq1_n, as_in, ps_in, c_as, c_ps;
  logic cpu_clk_en, periph_clk_en, osc_en, sfr_reset, wake_vector, emul;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] vsrc;
  logic [7:0] hi, p0;
  mpe_pkg::mpe_strobe_t strb;
  mpe_pkg::mpe_port_t port0, port1, port2, port3;
  int n_errors, n_tests;

  mpe_ctrl mpe_ctrl_inst (.clock(clock), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rst_pin(rst_pin), .instr_done(instr_done), .irq_pending(irq_pending),
    .ext_irq_zero_n(irq0_n), .ext_irq_one_n(irq1_n),
    .addr_strobe_in(as_in), .prog_strobe_in(ps_in),
    .core_addr_strobe(c_as), .core_prog_strobe(c_ps), .cpu_addr_hi(hi),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_en(osc_en), .sfr_reset(sfr_reset), .wake_vector(wake_vector),
    .vector_src(vsrc), .emul_mode(emul), .strobe_pins(strb),
    .port0(port0), .port1(port1), .port2(port2), .port3(port3));
  mpe_core_model mpe_core_model_inst (.clock(clock), .rst_n(rst_n),
    .cpu_clk_en(cpu_clk_en), .instr_done(instr_done),
    .core_addr_strobe(c_as), .core_prog_strobe(c_ps), .cpu_addr_hi(hi));

  always #20 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic ck(input logic [31:0] g, input logic [31:0] x,
    input string m);
    n_tests++;
    if (g !== x)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Entered right after an edge; idle edge first keeps psel single-driven
  task automatic ap(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    ck(pready, 1, "no ready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic sg(input int s);
    case (s)
      0: return cpu_clk_en;
      1: return osc_en;
      2: return wake_vector;
      3: return emul;
      default: return sfr_reset;
    endcase
  endfunction

  task automatic wt(input int s, input logic v);
    int n;
    for (n = 0; n < 200 && sg(s) !== v; n++)
      @(posedge clock);
    ck(sg(s), v, "wait ran out");
  endtask

  task automatic rp(input int n);
    rst_pin <= 1'b1;
    repeat (n) @(posedge clock);
    rst_pin <= 1'b0;
  endtask

  task print_verdict;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    print_verdict;
  end

  initial
  begin
    clock = 1'b0;
    rst_n <= 1'b0;
    {psel, penable, pwrite, rst_pin, irq_pending} <= 5'h0;
    {irq0_n, irq1_n, as_in, ps_in} <= 4'hf;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    foreach (ROWS[i])
    begin
      ap(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      ck(e, ROWS[i].e, "slave error");
      if (!ROWS[i].w && !ROWS[i].e)
        ck(r, ROWS[i].d, "read data");
    end
    // Idle with a flag set alongside
    ap(1'b1, PC, 32'h5);
    wt(0, 1'b0);
    p0 = port0.dout;
    // Register write while gated must be dropped
    ap(1'b1, CF, 32'h0);
    ck(periph_clk_en, 1, "periph clock");
    ck({strb.addr_strb, strb.prog_strb}, 2'h3, "idle strobes");
    ck({port0.dout, port0.oe}, 16'ha55a, "port0 drive");
    repeat (10) @(posedge clock);
    ck(port0.dout, p0, "port freeze");
    ck(cpu_clk_en, 0, "cpu frozen");
    irq_pending <= 1'b1;
    wt(2, 1'b1);
    irq_pending <= 1'b0;
    ck(cpu_clk_en, 1, "idle exit");
    ap(1'b0, PC, 32'h0);
    ck(r[3:0], 4'h4, "idle bit");
    ap(1'b0, CF, 32'h0);
    ck(r[3:0], 4'h6, "cfg in idle");
    // Power-down, external memory, first pin only
    ap(1'b1, CF, 32'h3);
    ap(1'b1, PC, 32'h2);
    wt(1, 1'b0);
    ck({strb.addr_strb, strb.prog_strb}, 2'h0, "pd strobes");
    ck(port0.oe, 8'h00, "port0 float");
    ck(port2.dout, 8'h00, "port2 data");
    irq1_n <= 1'b0;
    irq_pending <= 1'b1;
    repeat (8) @(posedge clock);
    ck(osc_en, 0, "bad wake");
    {irq1_n, irq_pending, irq0_n} <= 3'h4;
    wt(1, 1'b1);
    repeat (4) @(posedge clock);
    ck(cpu_clk_en, 0, "early exit");
    irq0_n <= 1'b1;
    wt(2, 1'b1);
    ck(vsrc, mpe_pkg::SRC_EXT0, "wake source");
    ap(1'b0, PC, 32'h0);
    ck(r[1:0], 2'h0, "pd bit");
    ap(1'b0, CF, 32'h0);
    ck(r[3:0], 4'h3, "cfg kept");
    // Both requests, both pins, second pin higher priority
    ap(1'b1, CF, 32'he);
    ap(1'b1, PC, 32'h3);
    wt(1, 1'b0);
    {irq0_n, irq1_n} <= 2'h0;
    wt(1, 1'b1);
    irq0_n <= 1'b1;
    wt(2, 1'b1);
    ck(vsrc, mpe_pkg::SRC_EXT1, "priority");
    irq1_n <= 1'b1;
    ap(1'b0, PC, 32'h0);
    ck({cpu_clk_en, r[1:0]}, 3'h4, "no idle");
    // Pin reset out of idle: one short of the count, then full
    ap(1'b1, PC, 32'h1);
    wt(0, 1'b0);
    rp(23);
    repeat (3) @(posedge clock);
    ck(cpu_clk_en, 0, "short reset");
    rp(24);
    wt(4, 1'b1);
    ap(1'b0, CF, 32'h0);
    ck(r[3:0], 4'h0, "cfg cleared");
    ap(1'b0, RB, 32'h0);
    ck(r[7:0], 8'h55, "ram kept");
    ap(1'b0, PC, 32'h0);
    ck({cpu_clk_en, r[1:0]}, 3'h4, "reset exit");
    // Strap ignored while the program strobe is low
    {as_in, ps_in} <= 2'h0;
    rp(30);
    repeat (3) @(posedge clock);
    ck(emul, 0, "strap without strobe");
    ps_in <= 1'b1;
    // Emulation strap held through release
    as_in <= 1'b0;
    rp(30);
    repeat (2) @(posedge clock);
    as_in <= 1'b1;
    wt(3, 1'b1);
    ck({port0.pull, port1.pull, port2.pull, port3.pull, strb.pull}, 5'hf,
      "pulls");
    ck({port0.oe, port1.oe, port2.oe, port3.oe}, 32'h0,
      "emul ports");
    ck({strb.addr_strb_oe, strb.prog_strb_oe, osc_en}, 3'h1,
      "emul drive");
    rp(24);
    wt(3, 1'b0);
    print_verdict;
  end
endmodule // mcu_idle_powerdown_emulation_ctrl_test
`default_nettype wire

// ### dv/mpe_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpe_core_model
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cpu_clk_en,
  output logic instr_done,
  output logic core_addr_strobe,
  output logic core_prog_strobe,
  output logic [7:0] cpu_addr_hi
);
  logic [1:0] cnt_reg;
  ////////////////////////////////////////////////////////////////////////
  // Gated core: no fetch, no strobes, address frozen
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 2'h0;
      instr_done <= 1'b0;
      core_addr_strobe <= 1'b0;
      core_prog_strobe <= 1'b0;
      cpu_addr_hi <= 8'h00;
    end
    else if (cpu_clk_en)
    begin
      cnt_reg <= cnt_reg + 2'h1;
      instr_done <= (cnt_reg == 2'h3);
      core_addr_strobe <= ~core_addr_strobe;
      core_prog_strobe <= cnt_reg[1];
      cpu_addr_hi <= cpu_addr_hi + 8'h01;
    end
    else
    begin
      instr_done <= 1'b0;
    end
  end
endmodule // mpe_core_model
`default_nettype wire

// ### verilog/mpe_ctrl.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mpe_ctrl
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rst_pin,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic ext_irq_zero_n,
  input wire logic ext_irq_one_n,
  input wire logic addr_strobe_in,
  input wire logic prog_strobe_in,
  input wire logic core_addr_strobe,
  input wire logic core_prog_strobe,
  input wire logic [7:0] cpu_addr_hi,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic sfr_reset,
  output logic wake_vector,
  output logic [1:0] vector_src,
  output logic emul_mode,
  output var mpe_pkg::mpe_strobe_t strobe_pins,
  output var mpe_pkg::mpe_port_t port0,
  output var mpe_pkg::mpe_port_t port1,
  output var mpe_pkg::mpe_port_t port2,
  output var mpe_pkg::mpe_port_t port3
);
  mpe_pkg::mpe_state_t state_reg;
  mpe_pkg::mpe_state_t state_next;
  logic [3:0] power_control_reg;
  logic [3:0] power_control_next;
  logic [3:0] cfg_reg;
  logic [31:0] port_data_reg;
  logic [4:0] rst_cnt_reg;
  logic emul_arm_reg;
  logic [1:0] wake_mask_reg;
  logic [1:0] wake_low;
  logic [1:0] released;
  logic reset_done;
  logic emul_enter;
  logic idle_wake;
  logic pd_wake;
  logic apb_access;
  logic wr_fire;
  logic sfr_wr_ok;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic [31:0] read_mux;

  function automatic logic ram_hit(input logic [11:0] a);
    return a[11:6] == mpe_pkg::RAM_BASE[11:6];
  endfunction

  function automatic logic addr_hit(input logic [11:0] a);
    return (a[1:0] == 2'h0) && (ram_hit(a) ||
      a == mpe_pkg::POWER_CONTROL_ADDR || a == mpe_pkg::CFG_ADDR ||
      a == mpe_pkg::PORT_ADDR || a == mpe_pkg::STAT_ADDR);
  endfunction

  function automatic logic [1:0] pick_src(input logic [1:0] m,
                                          input logic prio_one);
    if (m == 2'h3)
      return prio_one ? mpe_pkg::SRC_EXT1 : mpe_pkg::SRC_EXT0;
    else if (m[1])
      return mpe_pkg::SRC_EXT1;
    else
      return mpe_pkg::SRC_EXT0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset pin qualification and emulation strap

  always_ff @(posedge clock)
  begin
    if (!rst_n || !rst_pin)
    begin
      rst_cnt_reg <= '0;
    end
    else if (rst_cnt_reg != mpe_pkg::RST_CNT_FULL)
    begin
      rst_cnt_reg <= rst_cnt_reg + 5'h01;
    end
  end

  // Oscillator runs in Idle, so a count of clocks is enough
  assign reset_done = rst_pin && (rst_cnt_reg == mpe_pkg::RST_CNT_LAST);

  // Latest strobe levels seen while reset is held
  always_ff @(posedge clock)
  begin
    if (!rst_n || !rst_pin)
    begin
      emul_arm_reg <= 1'b0;
    end
    else
    begin
      emul_arm_reg <= !addr_strobe_in && prog_strobe_in;
    end
  end

  // Strobe must still be low on the release cycle
  assign emul_enter = !rst_pin && (rst_cnt_reg == mpe_pkg::RST_CNT_FULL)
                      && emul_arm_reg && !addr_strobe_in;

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  assign wake_low = {cfg_reg[mpe_pkg::IRQ1_EN_BIT] && !ext_irq_one_n,
                     cfg_reg[mpe_pkg::IRQ0_EN_BIT] && !ext_irq_zero_n};
  assign released = wake_mask_reg & {ext_irq_one_n, ext_irq_zero_n};

  always_comb
  begin
    state_next = state_reg;
    if (reset_done)
    begin
      state_next = mpe_pkg::ST_RUN;
    end
    else if (emul_enter)
    begin
      state_next = mpe_pkg::ST_EMUL;
    end
    else if (!rst_pin)
    begin
      case (state_reg)
        mpe_pkg::ST_RUN:
        begin
          // Power-down wins when both requests are set
          if (instr_done && power_control_reg[mpe_pkg::PDOWN_REQ_BIT])
            state_next = mpe_pkg::ST_PDOWN;
          else if (instr_done && power_control_reg[mpe_pkg::IDLE_REQ_BIT])
            state_next = mpe_pkg::ST_IDLE;
        end
        mpe_pkg::ST_IDLE:
        begin
          if (irq_pending)
            state_next = mpe_pkg::ST_RUN;
        end
        mpe_pkg::ST_PDOWN:
        begin
          if (wake_low != 2'h0)
            state_next = mpe_pkg::ST_WAKE;
        end
        mpe_pkg::ST_WAKE:
        begin
          if (released != 2'h0)
            state_next = mpe_pkg::ST_RUN;
        end
        mpe_pkg::ST_EMUL:
        begin
          state_next = mpe_pkg::ST_EMUL;
        end
        default:
        begin
          state_next = mpe_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= mpe_pkg::ST_RUN;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign idle_wake = (state_reg == mpe_pkg::ST_IDLE)
                     && (state_next == mpe_pkg::ST_RUN) && !reset_done;
  assign pd_wake = (state_reg == mpe_pkg::ST_WAKE)
                   && (state_next == mpe_pkg::ST_RUN) && !reset_done;

  // Either pin may join while the oscillator restarts
  always_ff @(posedge clock)
  begin
    if (!rst_n || state_next != mpe_pkg::ST_WAKE)
    begin
      wake_mask_reg <= 2'h0;
    end
    else if (state_reg == mpe_pkg::ST_WAKE)
    begin
      wake_mask_reg <= wake_mask_reg | wake_low;
    end
    else
    begin
      wake_mask_reg <= wake_low;
    end
  end

  // Core vectors and later returns to the instruction after the request
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wake_vector <= 1'b0;
      vector_src <= mpe_pkg::SRC_CTRL;
    end
    else
    begin
      wake_vector <= idle_wake || pd_wake;
      if (pd_wake)
        vector_src <= pick_src(wake_mask_reg,
                               cfg_reg[mpe_pkg::IRQ1_PRIO_BIT]);
      else if (idle_wake)
        vector_src <= mpe_pkg::SRC_CTRL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock, oscillator and reset controls

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      sfr_reset <= 1'b0;
      emul_mode <= 1'b0;
    end
    else
    begin
      // CPU clock gated keeps every core register except instr_done, which clears, as it was
      cpu_clk_en <= state_next == mpe_pkg::ST_RUN;
      periph_clk_en <= state_next == mpe_pkg::ST_RUN
                       || state_next == mpe_pkg::ST_IDLE;
      // Reset pin restarts the oscillator too
      osc_en <= state_next != mpe_pkg::ST_PDOWN || rst_pin;
      sfr_reset <= reset_done;
      emul_mode <= state_next == mpe_pkg::ST_EMUL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  assign apb_access = psel && penable;
  assign wr_fire = apb_access && pready && pwrite && addr_hit(paddr);
  // Config, port and RAM writes frozen outside normal run; power control stays writable
  assign sfr_wr_ok = wr_fire && (state_reg == mpe_pkg::ST_RUN);
  assign ram_we = sfr_wr_ok && ram_hit(paddr);

  always_comb
  begin
    power_control_next = power_control_reg;
    if (idle_wake)
      power_control_next[mpe_pkg::IDLE_REQ_BIT] = 1'b0;
    if (pd_wake)
    begin
      power_control_next[mpe_pkg::IDLE_REQ_BIT] = 1'b0;
      power_control_next[mpe_pkg::PDOWN_REQ_BIT] = 1'b0;
    end
    // Software write lands after the hardware clear, so a set wins
    if (wr_fire && paddr == mpe_pkg::POWER_CONTROL_ADDR)
      power_control_next = pwdata[3:0];
    if (reset_done)
      power_control_next = mpe_pkg::POWER_CONTROL_RST;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      power_control_reg <= mpe_pkg::POWER_CONTROL_RST;
    end
    else
    begin
      power_control_reg <= power_control_next;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n || reset_done)
    begin
      cfg_reg <= mpe_pkg::CFG_RST;
      port_data_reg <= mpe_pkg::PORT_RST;
    end
    else if (sfr_wr_ok && paddr == mpe_pkg::CFG_ADDR)
    begin
      cfg_reg <= pwdata[3:0];
    end
    else if (sfr_wr_ok && paddr == mpe_pkg::PORT_ADDR)
    begin
      port_data_reg <= pwdata;
    end
  end

  mpe_ram u_ram
  (
    .clock(clock),
    .rst_n(rst_n),
    .we(ram_we),
    .waddr(paddr[5:2]),
    .wdata(pwdata[7:0]),
    .raddr(paddr[5:2]),
    .rdata(ram_rdata)
  );

  always_comb
  begin
    read_mux = 32'h0;
    if (ram_hit(paddr))
      read_mux = {24'h0, ram_rdata};
    else
    begin
      case (paddr)
        mpe_pkg::POWER_CONTROL_ADDR: read_mux = {28'h0, power_control_reg};
        mpe_pkg::CFG_ADDR: read_mux = {28'h0, cfg_reg};
        mpe_pkg::PORT_ADDR: read_mux = port_data_reg;
        mpe_pkg::STAT_ADDR:
          read_mux = {21'h0, wake_mask_reg, rst_cnt_reg, emul_mode,
                      state_reg};
        default: read_mux = 32'h0;
      endcase
    end
  end

  // One wait state: RAM data arrive one cycle after the address
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= apb_access && !pready;
      pslverr <= apb_access && !pready && !addr_hit(paddr);
      if (apb_access && !pready)
        prdata <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      strobe_pins <= mpe_pkg::STROBE_RST;
      port0 <= mpe_pkg::PORT_PINS_RST;
      port1 <= mpe_pkg::PORT_PINS_RST;
      port2 <= mpe_pkg::PORT_PINS_RST;
      port3 <= mpe_pkg::PORT_PINS_RST;
    end
    else
    begin
      case (state_next)
        mpe_pkg::ST_RUN:
        begin
          // Strobes released during reset so a strap can be sensed
          if (rst_pin)
            strobe_pins <= mpe_pkg::STROBE_RST;
          else
            strobe_pins <= '{core_addr_strobe, 1'b1,
                             core_prog_strobe, 1'b1, 1'b0};
          port0.dout <= port_data_reg[7:0];
          port0.oe <= cfg_reg[mpe_pkg::EXT_MEM_BIT] ? 8'h00
                      : ~port_data_reg[7:0];
          port0.pull <= 1'b0;
          port1 <= '{port_data_reg[15:8], 8'hff, 1'b0};
          port2.dout <= cfg_reg[mpe_pkg::EXT_MEM_BIT] ? cpu_addr_hi
                        : port_data_reg[23:16];
          port2.oe <= 8'hff;
          port2.pull <= 1'b0;
          port3 <= '{port_data_reg[31:24], 8'hff, 1'b0};
        end
        mpe_pkg::ST_IDLE:
        begin
          // Ports simply hold; port 2 keeps the address it had
          strobe_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end
        mpe_pkg::ST_PDOWN, mpe_pkg::ST_WAKE:
        begin
          strobe_pins <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
          port2.dout <= port_data_reg[23:16];
          port2.oe <= 8'hff;
        end
        mpe_pkg::ST_EMUL:
        begin
          strobe_pins <= mpe_pkg::STROBE_RST;
          port0 <= '{8'hff, 8'h00, 1'b0};
          port1 <= mpe_pkg::PORT_PINS_RST;
          port2 <= mpe_pkg::PORT_PINS_RST;
          port3 <= mpe_pkg::PORT_PINS_RST;
        end
        default:
        begin
          strobe_pins <= mpe_pkg::STROBE_RST;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  idle_entry_a: assert property (
    state_reg == mpe_pkg::ST_RUN && instr_done && !rst_pin
    && rst_cnt_reg == 5'h00 && power_control_reg == 4'h1
    |=> state_reg == mpe_pkg::ST_IDLE)
    else $error("idle not entered after request");

  clock_gate_a: assert property (
    state_reg == mpe_pkg::ST_IDLE |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");

  cpu_freeze_a: assert property (
    state_reg == mpe_pkg::ST_IDLE && !reset_done
    |=> $stable(port_data_reg) && $stable(cfg_reg))
    else $error("core registers changed in idle");

  pin_freeze_a: assert property (
    state_reg == mpe_pkg::ST_IDLE ##1 state_reg == mpe_pkg::ST_IDLE
    |-> $stable(port1) && $stable(port3) && $stable(port0))
    else $error("port pins moved in idle");

  strobe_mode_a: assert property (
    state_reg == mpe_pkg::ST_PDOWN
    |-> !strobe_pins.addr_strb && !strobe_pins.prog_strb
    && strobe_pins.addr_strb_oe)
    else $error("strobes not low in power-down");

  idle_wake_a: assert property (
    state_reg == mpe_pkg::ST_IDLE && irq_pending && !rst_pin && !apb_access
    |=> state_reg == mpe_pkg::ST_RUN && wake_vector
    && !power_control_reg[mpe_pkg::IDLE_REQ_BIT])
    else $error("idle wake failed");

  reset_exit_a: assert property (
    rst_pin && rst_cnt_reg == mpe_pkg::RST_CNT_LAST
    |=> state_reg == mpe_pkg::ST_RUN && sfr_reset
    && power_control_reg == 4'h0)
    else $error("reset did not complete");

  pd_entry_a: assert property (
    state_reg == mpe_pkg::ST_RUN && instr_done && !rst_pin
    && rst_cnt_reg == 5'h00 && power_control_reg[mpe_pkg::PDOWN_REQ_BIT]
    |=> state_reg == mpe_pkg::ST_PDOWN && !osc_en && !cpu_clk_en)
    else $error("power-down not entered");

  pd_hold_a: assert property (
    state_reg == mpe_pkg::ST_PDOWN && !rst_pin && wake_low == 2'h0
    |=> state_reg == mpe_pkg::ST_PDOWN)
    else $error("power-down left without cause");

  wake_osc_a: assert property (
    state_reg == mpe_pkg::ST_WAKE |-> osc_en && !cpu_clk_en)
    else $error("oscillator not restarted");

  pd_exit_a: assert property (
    state_reg == mpe_pkg::ST_WAKE && released != 2'h0 && !rst_pin
    && !apb_access
    |=> state_reg == mpe_pkg::ST_RUN && wake_vector
    && power_control_reg[1:0] == 2'h0)
    else $error("power-down exit wrong");

  emul_pins_a: assert property (
    state_reg == mpe_pkg::ST_EMUL
    |-> port1.oe == 8'h00 && port1.pull && port0.oe == 8'h00
    && !port0.pull && strobe_pins.pull && osc_en)
    else $error("emulation pin states wrong");

  emul_entry_a: assert property (
    emul_enter |=> state_reg == mpe_pkg::ST_EMUL ##1 emul_mode)
    else $error("emulation not entered");

  idle_trip_c: cover property (
    state_reg == mpe_pkg::ST_IDLE ##1 state_reg == mpe_pkg::ST_RUN);
  pd_wake_c: cover property (
    state_reg == mpe_pkg::ST_WAKE ##1 state_reg == mpe_pkg::ST_RUN);
  emul_c: cover property (emul_enter);
  both_req_c: cover property (
    state_reg == mpe_pkg::ST_PDOWN && power_control_reg[1:0] == 2'h3);
endmodule // mpe_ctrl
`default_nettype wire

// ### verilog/mpe_pkg.sv
// Notes on behaviour
// - Idle request set ends the current instruction, then Idle begins.
// - In Idle the CPU clock stops; peripheral clocks keep running.
// - All CPU state stays unchanged throughout Idle.
// - Port pins freeze at their level on entry to Idle.
// - Strobes high in Idle, low in power-down; port 0 per memory; port 2 per memory in Idle, port data in power-down.
// - Enabled interrupt in Idle clears idle request and resumes after return.
// - Reset held 24 oscillator periods completes reset and leaves Idle.
// - Power-down request ends the current instruction, then stops oscillator.
// - Internal RAM and special registers are retained in power-down.
// - Power-down ends only by hardware reset or external interrupt.
// - Only the two enabled external interrupt pins wake power-down.
// - Low wake pin restarts the oscillator; its release completes the exit.
// - With both pins, first release exits; higher priority handler runs.
// - After the wake handler, execution continues after the request.
// - Reset exit reinitialises special registers; interrupt exit keeps them.
// - Internal RAM survives either way out of power-down.
// - Both requests set: power-down exit, both bits cleared, no Idle.
// - Emulation: strobes and ports 1-3 pulled up, port 0 floats.
// - An ordinary reset leaves emulation mode.
// - Control register index 87h: idle bit 0, power-down bit 1.
`default_nettype none
package mpe_pkg;
  localparam logic [7:0] POWER_CONTROL_IDX = 8'h87;
  localparam logic [11:0] POWER_CONTROL_ADDR = {2'h0, POWER_CONTROL_IDX, 2'h0};
  localparam logic [11:0] CFG_ADDR = 12'h000;
  localparam logic [11:0] PORT_ADDR = 12'h004;
  localparam logic [11:0] STAT_ADDR = 12'h008;
  localparam logic [11:0] RAM_BASE = 12'h100;
  localparam int RAM_AW = 4;
  localparam int RAM_DW = 8;

  localparam int IDLE_REQ_BIT = 0;
  localparam int PDOWN_REQ_BIT = 1;
  localparam int FLAG_ZERO_BIT = 2;
  localparam int FLAG_ONE_BIT = 3;
  localparam logic [3:0] POWER_CONTROL_RST = 4'h0;

  localparam int EXT_MEM_BIT = 0;
  localparam int IRQ0_EN_BIT = 1;
  localparam int IRQ1_EN_BIT = 2;
  localparam int IRQ1_PRIO_BIT = 3;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [31:0] PORT_RST = 32'hffffffff;

  localparam int RST_HOLD_OSC = 24;
  localparam int CLK_PER_OSC = 1;
  localparam int RST_HOLD_CYC = RST_HOLD_OSC * CLK_PER_OSC;
  localparam logic [4:0] RST_CNT_LAST = 5'(RST_HOLD_CYC - 1);
  localparam logic [4:0] RST_CNT_FULL = 5'(RST_HOLD_CYC);

  localparam logic [1:0] SRC_CTRL = 2'h0;
  localparam logic [1:0] SRC_EXT0 = 2'h1;
  localparam logic [1:0] SRC_EXT1 = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_IDLE = 3'h1,
    ST_PDOWN = 3'h3,
    ST_WAKE = 3'h2,
    ST_EMUL = 3'h6
  } mpe_state_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic pull;
  } mpe_port_t;

  typedef struct packed {
    logic addr_strb;
    logic addr_strb_oe;
    logic prog_strb;
    logic prog_strb_oe;
    logic pull;
  } mpe_strobe_t;

  localparam mpe_port_t PORT_PINS_RST = '{8'hff, 8'h00, 1'b1};
  localparam mpe_strobe_t STROBE_RST = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
endpackage
`default_nettype wire

// ### verilog/mpe_ram.sv
`timescale 1ns/1ps
`default_nettype none
module mpe_ram
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [mpe_pkg::RAM_AW-1:0] waddr,
  input wire logic [mpe_pkg::RAM_DW-1:0] wdata,
  input wire logic [mpe_pkg::RAM_AW-1:0] raddr,
  output logic [mpe_pkg::RAM_DW-1:0] rdata
);
  // No reset on the array: contents must survive every reset
  logic [mpe_pkg::RAM_DW-1:0] mem [2**mpe_pkg::RAM_AW];

  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule // mpe_ram
`default_nettype wire
